// ===== common/page_accept_pkg.sv
// How it works
// - Outside an enclave: general protection fault, error code zero.
// - Security-info address not 64-byte aligned: general protection fault.
// - Security-info address outside enclave linear range: general protection fault.
// - Security-info address not in protected page cache: page fault.
// - Security-info page must be valid, readable, regular, clean, unblocked, owned, tagged.
// - Copy 64-byte block to 512-bit scratch; nonzero reserved field faults.
// - Destination not 4-kilobyte aligned: general protection fault.
// - Destination outside range faults; destination not in page cache page-faults.
// - Without capability only regular or thread-control/trimmed request combinations are legal.
// - With capability shadow-stack types with pending only are also legal.
// - Destination entry must be valid, unblocked, known type, owned, else page fault.
// - Page in use faults; then recheck valid and owner, else page fault.
// - Destination held exclusively against accept and modify operations during the check.
// - Mismatch of tag, pending, modified, read/write/execute or type sets zero flag, returns mismatch code, finishes.
// - Incomplete tracking sets zero flag, returns tracking code, page untouched.
// - Thread-control request: bad reserved, debug, index, exit or shadow pointer faults.
// - Thread-control page in narrow enclave needs both segment limits ending FFFH.
// - Success clears pending, modified, restriction flags, zero flag and accumulator.
// - Every non-faulting completion clears carry, parity, adjust, overflow, sign flags.
// - In 64-bit mode a non-canonical operand address is a general protection fault.
package page_accept_pkg;
	localparam logic [31:0] LEAF_PAGE_ACCEPT = 32'h0000_0005;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ACC = 8'h04;
	localparam logic [7:0] REG_SEC_LO = 8'h08;
	localparam logic [7:0] REG_SEC_HI = 8'h0C;
	localparam logic [7:0] REG_DST_LO = 8'h10;
	localparam logic [7:0] REG_DST_HI = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_FADDR_LO = 8'h1C;
	localparam logic [7:0] REG_FADDR_HI = 8'h20;
	localparam logic [7:0] REG_FLAGS = 8'h24;
	localparam logic [7:0] REG_CONFIG = 8'h28;
	// Status and config bits
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_FAULT = 2;
	localparam int STAT_PF = 3;
	localparam int CFG_SS_CAP = 0;
	localparam int CFG_WIDE = 1;
	// Flag register bit positions
	localparam int FL_CF = 0;
	localparam int FL_PF = 2;
	localparam int FL_AF = 4;
	localparam int FL_ZF = 6;
	localparam int FL_SF = 7;
	localparam int FL_OF = 11;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
	// Return codes
	localparam logic [31:0] CODE_OK = 32'h0000_0000;
	localparam logic [31:0] ATTRIBUTE_MISMATCH_CODE = 32'h0000_0021;
	localparam logic [31:0] TRACKING_INCOMPLETE_CODE = 32'h0000_0022;
	// Page types
	localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
	localparam logic [7:0] THREAD_CONTROL_PAGE_TYPE = 8'h02;
	localparam logic [7:0] TRIMMED_PAGE_TYPE = 8'h04;
	localparam logic [7:0] SHADOW_STACK_FIRST_TYPE = 8'h05;
	localparam logic [7:0] SHADOW_STACK_REST_TYPE = 8'h06;
	// Security-info flags word layout
	localparam int SI_R = 0;
	localparam int SI_W = 1;
	localparam int SI_X = 2;
	localparam int SI_PENDING = 3;
	localparam int SI_MODIFIED = 4;
	localparam int SI_PR = 5;
	localparam int SI_PT_LO = 8;
	localparam logic [63:0] SI_FLAGS_USED = 64'h0000_0000_0000_FF3F;
	localparam int SI_WORDS = 8;
	localparam int SI_ALIGN_BITS = 6;
	localparam int PAGE_BITS = 12;
	localparam logic [11:0] LIMIT_LOW_ONES = 12'hFFF;
	localparam int CANON_MSB = 47;

	typedef struct packed {
		logic resident;
		logic valid;
		logic blocked;
		logic r;
		logic w;
		logic x;
		logic pending;
		logic modified;
		logic pr;
		logic [7:0] pt;
		logic [63:0] page_owner_ref;
		logic [63:0] page_linear_tag;
	} map_entry_t;

	typedef struct packed {
		logic reserved_nz;
		logic debug_opt_in_flag;
		logic [31:0] current_save_area_index;
		logic [31:0] save_area_count;
		logic [63:0] async_exit_pointer;
		logic [63:0] state;
		logic [63:0] previous_shadow_stack_ptr;
		logic [31:0] first_segment_limit;
		logic [31:0] second_segment_limit;
	} tcs_fields_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef enum {
		ST_IDLE, ST_START, ST_SEC_MAP, ST_SEC_FETCH, ST_SEC_CHECK, ST_DST_MAP, ST_RECHECK
	} accept_state_t;
endpackage : page_accept_pkg

// ===== design/accept_combo_check.sv
// Legality of the requested type / pending / modified / restriction combination
module accept_combo_check
	import page_accept_pkg::*;
(
	// Request flags
	input wire logic [63:0] i_flags,
	input wire logic i_ss_capable,
	// Verdict
	output logic o_legal
);
	logic [7:0] pt;
	logic pend;
	logic modf;
	logic pr;
	logic reg_ok;
	logic tcs_ok;
	logic ss_ok;

	assign pt = i_flags[SI_PT_LO +: 8];
	assign pend = i_flags[SI_PENDING];
	assign modf = i_flags[SI_MODIFIED];
	assign pr = i_flags[SI_PR];
	assign reg_ok = (pt == REGULAR_PAGE_TYPE) && (pr || pend) && !modf;
	assign tcs_ok = ((pt == THREAD_CONTROL_PAGE_TYPE) || (pt == TRIMMED_PAGE_TYPE))
		&& !pr && !pend && modf;
	assign ss_ok = ((pt == SHADOW_STACK_FIRST_TYPE) || (pt == SHADOW_STACK_REST_TYPE))
		&& pend && !modf && !pr;
	assign o_legal = reg_ok || tcs_ok || (i_ss_capable && ss_ok);
endmodule : accept_combo_check

// ===== design/enclave_page_accept_check.sv
module enclave_page_accept_check
	import page_accept_pkg::*;
#(
	parameter int SCRATCH_BITS = 512
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire apb_req_t i_apb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Processor context
	input wire logic i_in_enclave,
	input wire logic [63:0] i_range_base,
	input wire logic [63:0] i_range_limit,
	input wire logic [63:0] i_active_enclave_control,
	input wire logic i_owner_wide_mode,
	input wire logic i_page_in_use,
	input wire logic i_tracking_done,
	input wire tcs_fields_t i_tcs,
	// Page map lookup
	output logic o_map_req,
	output logic [63:0] o_map_addr,
	input wire logic i_map_ack,
	input wire map_entry_t i_map_entry,
	// Page map update: clear pending, modified, restriction
	output logic o_map_wr,
	output logic [63:0] o_map_wr_addr,
	// Exclusive hold on destination page
	output logic o_page_hold,
	// Memory read of security-info block
	output logic o_mem_req,
	output logic [63:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [63:0] i_mem_data
);
	// Scratch copy is fixed at eight 64-bit words
	if (SCRATCH_BITS != SI_WORDS * 64) begin : g_bad_scratch
		$error("SCRATCH_BITS must equal eight 64-bit words");
	end

	typedef struct packed {
		accept_state_t st;
		logic [31:0] acc;
		logic [63:0] sec;
		logic [63:0] dst;
		logic [1:0] cfg;
		logic [31:0] flags;
		logic busy;
		logic done;
		logic fault;
		logic fault_pf;
		logic [63:0] fault_addr;
		logic [SI_WORDS-1:0][63:0] scratch;
		logic [2:0] beat;
		logic map_req;
		logic [63:0] map_addr;
		logic mem_req;
		logic [63:0] mem_addr;
		logic map_wr;
		logic hold;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_t;

	state_t s;
	state_t next_s;
	logic combo_legal;

	function automatic logic noncanonical(input logic [63:0] a, input logic wide);
		noncanonical = wide && !((&a[63:CANON_MSB]) || !(|a[63:CANON_MSB]));
	endfunction : noncanonical

	function automatic logic out_of_range(input logic [63:0] a, input logic [63:0] base,
		input logic [63:0] limit);
		out_of_range = (a < base) || (a > limit);
	endfunction : out_of_range

	function automatic logic [63:0] page_base(input logic [63:0] a);
		page_base = {a[63:PAGE_BITS], {PAGE_BITS{1'b0}}};
	endfunction : page_base

	accept_combo_check u_combo (
		.i_flags(s.scratch[0]),
		.i_ss_capable(s.cfg[CFG_SS_CAP]),
		.o_legal(combo_legal)
	);

	always_comb begin
		logic fin;
		logic fin_fault;
		logic fin_pf;
		logic [63:0] fin_addr;
		logic [31:0] fin_code;
		logic fin_zf;
		logic acc_phase;
		logic [63:0] si;
		map_entry_t e;
		fin = 1'b0;
		fin_fault = 1'b0;
		fin_pf = 1'b0;
		fin_addr = '0;
		fin_code = CODE_OK;
		fin_zf = 1'b0;
		si = s.scratch[0];
		e = i_map_entry;
		next_s = s;
		next_s.map_wr = 1'b0;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		acc_phase = i_apb.psel && i_apb.penable;

		// APB: one wait state, answer registered
		if (acc_phase && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.prdata = '0;
			case (i_apb.paddr)
				REG_CTRL: next_s.prdata = '0;
				REG_ACC: next_s.prdata = s.acc;
				REG_SEC_LO: next_s.prdata = s.sec[31:0];
				REG_SEC_HI: next_s.prdata = s.sec[63:32];
				REG_DST_LO: next_s.prdata = s.dst[31:0];
				REG_DST_HI: next_s.prdata = s.dst[63:32];
				REG_STATUS: next_s.prdata = {28'h0000000, s.fault_pf, s.fault, s.done, s.busy};
				REG_FADDR_LO: next_s.prdata = s.fault_addr[31:0];
				REG_FADDR_HI: next_s.prdata = s.fault_addr[63:32];
				REG_FLAGS: next_s.prdata = s.flags;
				REG_CONFIG: next_s.prdata = {30'h00000000, s.cfg};
				default: next_s.pslverr = 1'b1;
			endcase
		end
		if (acc_phase && s.pready && i_apb.pwrite && !s.busy) begin
			case (i_apb.paddr)
				REG_CTRL: begin
					if (i_apb.pwdata[0] && s.acc == LEAF_PAGE_ACCEPT) begin
						next_s.busy = 1'b1;
						next_s.done = 1'b0;
						next_s.fault = 1'b0;
						next_s.fault_pf = 1'b0;
						next_s.st = ST_START;
					end
				end
				REG_ACC: next_s.acc = i_apb.pwdata;
				REG_SEC_LO: next_s.sec[31:0] = i_apb.pwdata;
				REG_SEC_HI: next_s.sec[63:32] = i_apb.pwdata;
				REG_DST_LO: next_s.dst[31:0] = i_apb.pwdata;
				REG_DST_HI: next_s.dst[63:32] = i_apb.pwdata;
				REG_STATUS: begin
					if (i_apb.pwdata[STAT_DONE]) begin
						next_s.done = 1'b0;
					end
				end
				REG_FLAGS: next_s.flags = i_apb.pwdata;
				REG_CONFIG: next_s.cfg = i_apb.pwdata[1:0];
				default: ;
			endcase
		end

		// Check sequence; first failure ends it
		case (s.st)
			ST_IDLE: ;
			ST_START: begin
				fin = 1'b1;
				fin_fault = 1'b1;
				if (!i_in_enclave) begin
					fin_addr = '0;
				end else if (noncanonical(s.sec, s.cfg[CFG_WIDE])) begin
					fin_addr = '0;
				end else if (|s.sec[SI_ALIGN_BITS-1:0]) begin
					fin_addr = '0;
				end else if (out_of_range(s.sec, i_range_base, i_range_limit)) begin
					fin_addr = '0;
				end else begin
					fin = 1'b0;
					fin_fault = 1'b0;
					next_s.map_req = 1'b1;
					next_s.map_addr = page_base(s.sec);
					next_s.st = ST_SEC_MAP;
				end
			end
			ST_SEC_MAP: begin
				if (i_map_ack) begin
					next_s.map_req = 1'b0;
					if (!e.resident || !e.valid || !e.r || e.pending || e.modified
						|| e.blocked || e.pt != REGULAR_PAGE_TYPE
						|| e.page_owner_ref != i_active_enclave_control
						|| e.page_linear_tag != page_base(s.sec)) begin
						fin = 1'b1;
						fin_fault = 1'b1;
						fin_pf = 1'b1;
						fin_addr = s.sec;
					end else begin
						next_s.mem_req = 1'b1;
						next_s.mem_addr = s.sec;
						next_s.beat = '0;
						next_s.st = ST_SEC_FETCH;
					end
				end
			end
			ST_SEC_FETCH: begin
				if (i_mem_ack) begin
					next_s.scratch[s.beat] = i_mem_data;
					next_s.beat = s.beat + 3'd1;
					next_s.mem_addr = s.mem_addr + 64'h0000_0000_0000_0008;
					if (s.beat == 3'(SI_WORDS - 1)) begin
						next_s.mem_req = 1'b0;
						next_s.st = ST_SEC_CHECK;
					end
				end
			end
			ST_SEC_CHECK: begin
				fin = 1'b1;
				fin_fault = 1'b1;
				if ((|(si & ~SI_FLAGS_USED)) || (|s.scratch[SI_WORDS-1:1])) begin
					fin_addr = '0;
				end else if (noncanonical(s.dst, s.cfg[CFG_WIDE])) begin
					fin_addr = '0;
				end else if (|s.dst[PAGE_BITS-1:0]) begin
					fin_addr = '0;
				end else if (out_of_range(s.dst, i_range_base, i_range_limit)) begin
					fin_addr = '0;
				end else begin
					fin = 1'b0;
					fin_fault = 1'b0;
					next_s.map_req = 1'b1;
					next_s.map_addr = s.dst;
					next_s.st = ST_DST_MAP;
				end
			end
			ST_DST_MAP: begin
				if (i_map_ack) begin
					next_s.map_req = 1'b0;
					fin = 1'b1;
					fin_fault = 1'b1;
					if (!e.resident) begin
						fin_pf = 1'b1;
						fin_addr = s.dst;
					end else if (!combo_legal) begin
						fin_addr = '0;
					end else if (!e.valid || e.blocked
						|| !(e.pt == REGULAR_PAGE_TYPE || e.pt == THREAD_CONTROL_PAGE_TYPE
						|| e.pt == TRIMMED_PAGE_TYPE || e.pt == SHADOW_STACK_FIRST_TYPE
						|| e.pt == SHADOW_STACK_REST_TYPE)
						|| e.page_owner_ref != i_active_enclave_control) begin
						fin_pf = 1'b1;
						fin_addr = s.dst;
					end else if (i_page_in_use) begin
						fin_addr = '0;
					end else begin
						fin = 1'b0;
						fin_fault = 1'b0;
						next_s.hold = 1'b1;
						next_s.map_req = 1'b1;
						next_s.st = ST_RECHECK;
					end
				end
			end
			ST_RECHECK: begin
				if (i_map_ack) begin
					next_s.map_req = 1'b0;
					fin = 1'b1;
					if (!e.valid || e.page_owner_ref != i_active_enclave_control) begin
						fin_fault = 1'b1;
						fin_pf = 1'b1;
						fin_addr = s.dst;
					end else if (e.page_linear_tag != s.dst || e.pending != si[SI_PENDING]
						|| e.modified != si[SI_MODIFIED] || e.r != si[SI_R]
						|| e.w != si[SI_W] || e.x != si[SI_X]
						|| e.pt != si[SI_PT_LO +: 8]) begin
						fin_zf = 1'b1;
						fin_code = ATTRIBUTE_MISMATCH_CODE;
					end else if (!i_tracking_done) begin
						fin_zf = 1'b1;
						fin_code = TRACKING_INCOMPLETE_CODE;
					end else if (si[SI_PT_LO +: 8] == THREAD_CONTROL_PAGE_TYPE
						&& (i_tcs.reserved_nz || i_tcs.debug_opt_in_flag
						|| i_tcs.current_save_area_index >= i_tcs.save_area_count
						|| (|i_tcs.async_exit_pointer) || (|i_tcs.state)
						|| (s.cfg[CFG_SS_CAP] && (|i_tcs.previous_shadow_stack_ptr)))) begin
						fin_fault = 1'b1;
					end else if (si[SI_PT_LO +: 8] == THREAD_CONTROL_PAGE_TYPE
						&& !i_owner_wide_mode
						&& (i_tcs.first_segment_limit[11:0] != LIMIT_LOW_ONES
						|| i_tcs.second_segment_limit[11:0] != LIMIT_LOW_ONES)) begin
						fin_fault = 1'b1;
					end else begin
						next_s.map_wr = 1'b1;
					end
				end
			end
			default: next_s.st = ST_IDLE;
		endcase

		// Completion; map untouched unless every check passed
		if (fin) begin
			next_s.st = ST_IDLE;
			next_s.busy = 1'b0;
			next_s.done = 1'b1;
			next_s.hold = 1'b0;
			next_s.map_req = 1'b0;
			next_s.mem_req = 1'b0;
			if (fin_fault) begin
				next_s.fault = 1'b1;
				next_s.fault_pf = fin_pf;
				next_s.fault_addr = fin_addr;
			end else begin
				next_s.acc = fin_code;
				next_s.flags[FL_ZF] = fin_zf;
				next_s.flags[FL_CF] = 1'b0;
				next_s.flags[FL_PF] = 1'b0;
				next_s.flags[FL_AF] = 1'b0;
				next_s.flags[FL_OF] = 1'b0;
				next_s.flags[FL_SF] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.flags <= FLAGS_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign o_prdata = s.prdata;
	assign o_pready = s.pready;
	assign o_pslverr = s.pslverr;
	assign o_map_req = s.map_req;
	assign o_map_addr = s.map_addr;
	assign o_map_wr = s.map_wr;
	assign o_map_wr_addr = s.dst;
	assign o_page_hold = s.hold;
	assign o_mem_req = s.mem_req;
	assign o_mem_addr = s.mem_addr;
endmodule : enclave_page_accept_check

// ===== tb/enclave_page_accept_monitor.sv
module enclave_page_accept_monitor
	import page_accept_pkg::*;
#(
	parameter int SCRATCH_BITS = 512
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Context
	input wire logic i_in_enclave,
	input wire logic [63:0] i_range_base,
	input wire logic [63:0] i_range_limit,
	input wire logic [63:0] i_active_enclave_control,
	input wire logic i_page_in_use,
	input wire logic i_tracking_done,
	// Page map
	input wire logic o_map_req,
	input wire logic i_map_ack,
	input wire map_entry_t i_map_entry,
	input wire logic o_map_wr,
	input wire logic [63:0] o_map_wr_addr,
	input wire logic o_page_hold,
	// Block fetch
	input wire logic o_mem_req,
	input wire logic [63:0] o_mem_addr,
	input wire logic i_mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_inside;
		o_map_req |-> i_in_enclave;
	endproperty
	a_inside: assert property (p_inside) else $error("lookup outside enclave");
	property p_fetch_align;
		$rose(o_mem_req) |-> o_mem_addr[5:0] == 6'h00;
	endproperty
	a_fetch_align: assert property (p_fetch_align) else $error("fetch misaligned");
	property p_fetch_range;
		$rose(o_mem_req) |-> (o_mem_addr >= i_range_base) && (o_mem_addr <= i_range_limit);
	endproperty
	a_fetch_range: assert property (p_fetch_range) else $error("fetch out of range");
	property p_fetch_cause;
		$rose(o_mem_req) |-> $past(i_map_ack) && $past(i_map_entry.r) && !$past(i_map_entry.blocked);
	endproperty
	a_fetch_cause: assert property (p_fetch_cause) else $error("fetch without good entry");
	property p_fetch_step;
		i_mem_ack && o_mem_req |=> !o_mem_req || (o_mem_addr == $past(o_mem_addr) + 64'h8);
	endproperty
	a_fetch_step: assert property (p_fetch_step) else $error("fetch address step");
	property p_wr_align;
		o_map_wr |-> o_map_wr_addr[11:0] == 12'h000;
	endproperty
	a_wr_align: assert property (p_wr_align) else $error("map write misaligned");
	property p_wr_owner;
		o_map_wr |-> $past(i_map_ack) && $past(i_map_entry.valid)
			&& ($past(i_map_entry.page_owner_ref) == $past(i_active_enclave_control));
	endproperty
	a_wr_owner: assert property (p_wr_owner) else $error("map write without recheck");
	property p_hold;
		$rose(o_page_hold) |-> $past(i_map_ack) && !$past(i_page_in_use);
	endproperty
	a_hold: assert property (p_hold) else $error("hold taken on busy page");
	property p_wr_track;
		o_map_wr |-> $past(i_tracking_done);
	endproperty
	a_wr_track: assert property (p_wr_track) else $error("map write untracked");
	property p_wr_pulse;
		o_map_wr |-> $past(o_page_hold) ##1 !o_map_wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("map write not a held pulse");
endmodule : enclave_page_accept_monitor

bind enclave_page_accept_check enclave_page_accept_monitor #(.SCRATCH_BITS(SCRATCH_BITS)) mon (
	.i_clk(i_clk), .i_rst(i_rst), .i_in_enclave(i_in_enclave),
	.i_range_base(i_range_base), .i_range_limit(i_range_limit),
	.i_active_enclave_control(i_active_enclave_control), .i_page_in_use(i_page_in_use),
	.i_tracking_done(i_tracking_done), .o_map_req(o_map_req), .i_map_ack(i_map_ack),
	.i_map_entry(i_map_entry), .o_map_wr(o_map_wr), .o_map_wr_addr(o_map_wr_addr),
	.o_page_hold(o_page_hold), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
	.i_mem_ack(i_mem_ack)
);

// ===== tb/testbench.sv
module testbench
	import page_accept_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] GP = 32'h0000_0006;
	localparam logic [31:0] PG = 32'h0000_000E;
	localparam logic [31:0] OK = 32'h0000_0002;
	localparam logic [31:0] FS = 32'h0000_08D7;
	localparam logic [31:0] FZ = 32'h0000_0042;
	localparam logic [31:0] LF = LEAF_PAGE_ACCEPT;
	localparam logic [63:0] OWNER = 64'h0000_0000_0000_0ABC;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	apb_req_t apb_q = '0;
	logic i_in_enclave = 1'b0, i_owner_wide_mode = 1'b0, i_page_in_use = 1'b0;
	logic i_tracking_done = 1'b0, i_map_ack = 1'b0, i_mem_ack = 1'b0;
	logic [63:0] i_mem_data = 64'h0;
	tcs_fields_t i_tcs = '0;
	map_entry_t i_map_entry = '0;
	logic [31:0] o_prdata;
	logic o_pready, o_pslverr, o_map_req, o_map_wr, o_page_hold, o_mem_req;
	logic [63:0] o_map_addr, o_map_wr_addr, o_mem_addr;
	logic [63:0] sec, dst;
	logic [63:0] words [8];
	map_entry_t sec_e, dst_e;
	tcs_fields_t tcs;
	logic [31:0] cfg, q;
	logic enc, inuse, trk, wmode, e, lose;
	int wr_cnt = 0, cyc = 0, n_fail = 0, check_count = 0;

	enclave_page_accept_check dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb_q), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_in_enclave(i_in_enclave), .i_range_base(64'h1000_0000),
		.i_range_limit(64'h1FFF_FFFF), .i_active_enclave_control(OWNER),
		.i_owner_wide_mode(i_owner_wide_mode), .i_page_in_use(i_page_in_use),
		.i_tracking_done(i_tracking_done), .i_tcs(i_tcs), .o_map_req(o_map_req),
		.o_map_addr(o_map_addr), .i_map_ack(i_map_ack), .i_map_entry(i_map_entry),
		.o_map_wr(o_map_wr), .o_map_wr_addr(o_map_wr_addr), .o_page_hold(o_page_hold),
		.o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
		.i_mem_data(i_mem_data)
	);

	always #12.5 i_clk = ~i_clk;

	// Page map and memory responders; idle data toggles
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_map_wr === 1'b1)
			wr_cnt <= wr_cnt + 1;
		i_map_ack <= o_map_req === 1'b1 && !i_map_ack;
		if (o_map_req === 1'b1 && !i_map_ack)
			i_map_entry <= (o_map_addr[63:12] == sec[63:12]) ? sec_e
				: (lose && o_page_hold === 1'b1) ? map_entry_t'('0) : dst_e;
		else
			i_map_entry <= ~i_map_entry;
		i_mem_ack <= o_mem_req === 1'b1 && !i_mem_ack;
		if (o_mem_req === 1'b1 && !i_mem_ack)
			i_mem_data <= words[3'((o_mem_addr - sec) >> 3)];
		else
			i_mem_data <= ~i_mem_data;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
		check_count++;
		if (y !== x) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", s, x, y);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb_q <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_clk);
		apb_q.penable <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'b1);
		q = o_prdata;
		e = o_pslverr;
		apb_q <= '0;
		@(posedge i_clk);
	endtask : apb

	task automatic base();
		sec = 64'h1000_2040;
		dst = 64'h1000_5000;
		cfg = 32'h0;
		words = '{default: 64'h0};
		words[0] = 64'h0109;
		sec_e = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, REGULAR_PAGE_TYPE, OWNER,
			64'h1000_2000};
		dst_e = sec_e;
		dst_e.pending = 1'b1;
		dst_e.page_linear_tag = dst;
		tcs = '{1'b0, 1'b0, 32'h0, 32'h1, 64'h0, 64'h0, 64'h0, 32'h0FFF, 32'h0FFF};
		{enc, inuse, trk, wmode, lose} = 5'b10100;
	endtask : base

	task automatic run(input logic [31:0] e_st, e_acc, e_fl, e_fa, input int e_wr);
		int n;
		int w0;
		n = 0;
		w0 = wr_cnt;
		{i_in_enclave, i_page_in_use, i_tracking_done, i_owner_wide_mode} <= {enc, inuse, trk, wmode};
		i_tcs <= tcs;
		apb(1'b1, REG_STATUS, 32'h0000_0002);
		apb(1'b1, REG_CONFIG, cfg);
		apb(1'b1, REG_FLAGS, FS);
		apb(1'b1, REG_ACC, LF);
		apb(1'b1, REG_SEC_LO, sec[31:0]);
		apb(1'b1, REG_SEC_HI, sec[63:32]);
		apb(1'b1, REG_DST_LO, dst[31:0]);
		apb(1'b1, REG_DST_HI, dst[63:32]);
		apb(1'b1, REG_CTRL, 32'h0000_0001);
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (q[STAT_DONE] !== 1'b1 && n < 100);
		chk("status", e_st, q);
		apb(1'b0, REG_ACC, 32'h0);
		chk("acc", e_acc, q);
		apb(1'b0, REG_FLAGS, 32'h0);
		chk("flags", e_fl, q);
		apb(1'b0, REG_FADDR_LO, 32'h0);
		if (e_st[STAT_FAULT])
			chk("fault addr", e_fa, q);
		chk("map writes", e_wr, 32'(wr_cnt - w0));
	endtask : run

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	initial begin
		base();
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		apb(1'b0, REG_FLAGS, 32'h0);
		chk("flags reset", FLAGS_RESET, q);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		apb(1'b1, REG_ACC, 32'h0000_0007);
		apb(1'b1, REG_CTRL, 32'h0000_0001);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("wrong leaf start", 32'h0, q);
		run(OK, CODE_OK, OK, 0, 1);
		enc = 1'b0; run(GP, LF, FS, 0, 0);
		base(); sec += 8; run(GP, LF, FS, 0, 0);
		base(); sec = 64'h2000_0040; run(GP, LF, FS, 0, 0);
		base(); sec_e.resident = 1'b0; run(PG, LF, FS, sec[31:0], 0);
		base(); sec_e.pending = 1'b1; run(PG, LF, FS, sec[31:0], 0);
		base(); words[7] = 64'h1; run(GP, LF, FS, 0, 0);
		base(); words[0][6] = 1'b1; run(GP, LF, FS, 0, 0);
		base(); dst += 64'h800; run(GP, LF, FS, 0, 0);
		base(); dst = 64'h3000_0000; run(GP, LF, FS, 0, 0);
		base(); dst_e.resident = 1'b0; run(PG, LF, FS, dst[31:0], 0);
		base(); words[0] = 64'h0119; run(GP, LF, FS, 0, 0);
		base(); words[0] = 64'h0129; dst_e.pr = 1'b1; run(OK, CODE_OK, OK, 0, 1);
		base(); words[0] = 64'h0508; dst_e.pt = SHADOW_STACK_FIRST_TYPE; dst_e.r = 1'b0;
		run(GP, LF, FS, 0, 0);
		cfg = 32'h1; run(OK, CODE_OK, OK, 0, 1);
		base(); dst_e.blocked = 1'b1; run(PG, LF, FS, dst[31:0], 0);
		base(); dst_e.page_owner_ref = 64'h5; run(PG, LF, FS, dst[31:0], 0);
		base(); inuse = 1'b1; run(GP, LF, FS, 0, 0);
		base(); lose = 1'b1; run(PG, LF, FS, dst[31:0], 0);
		base(); dst_e.w = 1'b1; run(OK, ATTRIBUTE_MISMATCH_CODE, FZ, 0, 0);
		base(); dst_e.pending = 1'b0; run(OK, ATTRIBUTE_MISMATCH_CODE, FZ, 0, 0);
		base(); trk = 1'b0; run(OK, TRACKING_INCOMPLETE_CODE, FZ, 0, 0);
		base(); words[0] = 64'h0411; dst_e.pt = TRIMMED_PAGE_TYPE; dst_e.pending = 1'b0;
		dst_e.modified = 1'b1; run(OK, CODE_OK, OK, 0, 1);
		words[0] = 64'h0211; dst_e.pt = THREAD_CONTROL_PAGE_TYPE; run(OK, CODE_OK, OK, 0, 1);
		tcs.current_save_area_index = 32'h1; run(GP, LF, FS, 0, 0);
		tcs.current_save_area_index = 32'h0; tcs.debug_opt_in_flag = 1'b1;
		run(GP, LF, FS, 0, 0);
		tcs.debug_opt_in_flag = 1'b0; tcs.second_segment_limit = 32'h0FFE;
		run(GP, LF, FS, 0, 0);
		wmode = 1'b1; run(OK, CODE_OK, OK, 0, 1);
		base(); cfg = 32'h2; sec = 64'h0001_0000_1000_2040; run(GP, LF, FS, 0, 0);
		base(); sec_e.resident = 1'b0; dst += 64'h10; run(PG, LF, FS, sec[31:0], 0);
		summarize();
	end
endmodule : testbench
